/* File: src/ledphy_pkg.sv */
/*
  Shared constants and carrier types for the lamp and transceiver control
  register block: register indices, field positions, reset values, timing.
  Assumes a 200 MHz core clock and a 32-bit Avalon-MM register bus.
*/
package ledphy_pkg;

    ////////////////////////////////////////////////////////////////////////
    // bus geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int REG_W = 16;

    // register indices; byte address is four times the index
    localparam int IDX_LED_DIRECT = 'h18;
    localparam int IDX_PHY_CONTROL = 'h19;
    localparam logic [ADDR_W-1:0] ADDR_LED_DIRECT = ADDR_W'(IDX_LED_DIRECT * 4);
    localparam logic [ADDR_W-1:0] ADDR_PHY_CONTROL = ADDR_W'(IDX_PHY_CONTROL * 4);

    ////////////////////////////////////////////////////////////////////////
    // led_direct_control fields
    localparam int LED_RX_ONLY_BIT = 8;
    localparam int LED_BLINK_LSB = 6;
    localparam int LED_SPD_EN_BIT = 5;
    localparam int LED_LNK_EN_BIT = 4;
    localparam int LED_ACT_EN_BIT = 3;
    localparam int LED_SPD_VAL_BIT = 2;
    localparam int LED_LNK_VAL_BIT = 1;
    localparam int LED_ACT_VAL_BIT = 0;
    localparam int LED_STORED_W = 9;
    localparam logic [LED_STORED_W-1:0] LED_CTRL_RESET = 9'h000;

    // phy_control fields (upper part only)
    localparam int PHY_AUTO_X_BIT = 15;
    localparam int PHY_FORCED_X_BIT = 14;
    localparam int PHY_PAUSE_RX_BIT = 13;
    localparam int PHY_PAUSE_TX_BIT = 12;
    localparam int PHY_FORCE_ERR_BIT = 11;
    localparam int PHY_PAT_SEL_BIT = 10;
    localparam int PHY_RESULT_BIT = 9;
    localparam int PHY_RUN_BIT = 8;
    localparam int PHY_BYPASS_BIT = 7;
    localparam logic PHY_BIT_RESET = 1'b0;

    ////////////////////////////////////////////////////////////////////////
    // timing
    localparam int CLK_FREQ_HZ = 200_000_000;
    localparam int TICK_HZ = 1000;
    localparam int TICK_CYCLES = CLK_FREQ_HZ / TICK_HZ;
    localparam int STRETCH_MS = 50;
    localparam int STRETCH_TICKS = STRETCH_MS * TICK_HZ / 1000;
    localparam int BLINK_HZ_0 = 6;
    localparam int BLINK_HZ_1 = 12;
    localparam int BLINK_HZ_2 = 24;
    localparam int BLINK_HZ_3 = 48;
    localparam int CNT_W = 8;

    // pseudo-random self-test patterns: length and second tap
    localparam int PRBS_SHORT_LEN = 9;
    localparam int PRBS_SHORT_TAP = 5;
    localparam int PRBS_LONG_LEN = 15;
    localparam int PRBS_LONG_TAP = 14;
    localparam logic [PRBS_LONG_LEN-1:0] PRBS_SEED = 15'h7FFF;

    ////////////////////////////////////////////////////////////////////////
    // carriers
    typedef struct packed {
        logic link_up;
        logic speed_100;
        logic tx_activity;
        logic rx_activity;
        logic collision;
        logic blink_on_activity;
    } ledphy_line_status_s;

    typedef struct packed {
        logic asym_dir;
        logic pause;
    } ledphy_pause_adv_s;

endpackage

/* File: src/ledphy_stretch.sv */
/*
  Pulse stretcher for one lamp indication: holds a short event high for a
  fixed number of slow ticks, or passes it raw when bypassed.
  Assumes tick_in is a one-cycle enable from the parent's divider.
*/
`timescale 1ns/1ps
`default_nettype none
module ledphy_stretch
    import ledphy_pkg::*;
#(
    parameter logic [CNT_W-1:0] HOLD_TICKS = CNT_W'(STRETCH_TICKS)
)
(
    input wire logic clock_in,
    input wire logic resetn_in,
    input wire logic tick_in,
    input wire logic bypass_in,
    input wire logic pulse_in,
    output logic stretched_out
);

    logic [CNT_W-1:0] hold; // ticks left to keep lamp lit

    // reload on every event, count down on ticks
    always_ff @(posedge clock_in)
    begin
        if (!resetn_in)
        begin
            hold <= '0;
        end
        else if (pulse_in)
        begin
            hold <= HOLD_TICKS;
        end
        else if (tick_in && hold != '0)
        begin
            hold <= hold - 1'b1;
        end
    end

    // raw indication when stretching is bypassed
    always_ff @(posedge clock_in)
    begin
        if (!resetn_in)
        begin
            stretched_out <= 1'b0;
        end
        else
        begin
            stretched_out <= bypass_in ? pulse_in : (pulse_in || hold != '0);
        end
    end

endmodule
`default_nettype wire

/* File: src/ledphy_regs.sv */
/*
  Lamp direct control and upper transceiver control registers, reached over
  Avalon-MM, with lamp drive, crossover control, pause resolution and a
  pseudo-random self-test engine.
  Assumes synchronous line status inputs and a looped-back self-test bit.
  Operation list:
  // Operation
  // - upper seven lamp bits ignore writes, read zero
  // - lamp register reads stored values, not pins
  // - receive-only bit limits activity to receive
  // - blink field picks 6, 12, 24, 48 Hz
  // - speed override drives speed lamp force value
  // - link override drives link lamp force value
  // - activity override drives activity lamp force value
  // - three force values, read-write, reset zero
  // - auto crossover enable, reset from strap
  // - forced crossover swaps transmit and receive pairs
  // - pause receive resolved, full duplex only
  // - pause transmit resolved, full duplex only
  // - force error injects one error, self clears
  // - self-test runs on start bit, failure latched
  // - stretch bypass shows raw lamp indications
*/
// Register access over Avalon-MM was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module ledphy_regs
    import ledphy_pkg::*;
#(
    parameter int TICK_DIV = TICK_CYCLES
)
(
    input wire logic clock_in,
    input wire logic resetn_in,
    input wire logic [ADDR_W-1:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [DATA_W-1:0] avs_writedata_in,
    input wire logic [DATA_W/8-1:0] avs_byteenable_in,
    output logic [DATA_W-1:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    input wire ledphy_line_status_s line_status_in,
    input wire ledphy_pause_adv_s pause_local_in,
    input wire ledphy_pause_adv_s pause_partner_in,
    input wire logic hcd_full_duplex_in,
    input wire logic auto_crossover_strap_in,
    input wire logic selftest_rx_in,
    output logic speed_lamp_out,
    output logic link_lamp_out,
    output logic activity_collision_lamp_out,
    output logic auto_crossover_enable_out,
    output logic forced_crossover_out,
    output logic selftest_tx_out,
    output logic selftest_active_out
);

    ////////////////////////////////////////////////////////////////////////
    // declarations
    logic req; // any bus request
    logic take; // request accepted this edge
    logic wr_led; // accepted write to lamp register
    logic wr_phy; // accepted write to phy register
    logic [REG_W-1:0] led_view; // lamp register as read
    logic [REG_W-1:0] phy_view; // phy register as read
    logic [LED_STORED_W-1:0] led_ctrl; // stored lamp controls
    logic auto_crossover_enable; // crossover search enable
    logic forced_crossover; // pair swap
    logic selftest_pattern_select; // long pattern when set
    logic selftest_run; // start / stop
    logic lamp_stretch_bypass; // raw lamp indications
    logic selftest_force_error; // one error pending
    logic pause_rx; // resolved pause receive
    logic pause_tx; // resolved pause transmit
    logic selftest_result; // pass when set
    logic pat_long; // pattern frozen during a run
    logic [PRBS_LONG_LEN-1:0] gen; // generator state
    logic [PRBS_LONG_LEN-1:0] chk; // received bit history
    logic [4:0] fill; // bits in history so far, one extra for the idle bit
    logic gen_fb; // next generated bit
    logic chk_pred; // predicted received bit
    logic inject; // error goes out this cycle
    logic [$clog2(TICK_DIV)-1:0] div; // slow tick divider
    logic tick; // one-cycle slow enable
    logic activity; // qualified activity
    logic act_st; // stretched activity
    logic col_st; // stretched collision
    logic [CNT_W-1:0] blink_cnt; // ticks to next blink toggle
    logic [CNT_W-1:0] blink_half; // half period for chosen rate
    logic blink_phase; // blink on or off

    ////////////////////////////////////////////////////////////////////////
    // bus slave: one wait cycle, then answer for a single cycle
    assign req = avs_read_in || avs_write_in;
    assign take = req && !avs_waitrequest_out;
    assign wr_led = take && avs_write_in && avs_address_in == ADDR_LED_DIRECT;
    assign wr_phy = take && avs_write_in && avs_address_in == ADDR_PHY_CONTROL;

    // waitrequest drops for one cycle after a request is seen
    always_ff @(posedge clock_in)
    begin
        if (!resetn_in)
        begin
            avs_waitrequest_out <= 1'b1;
        end
        else if (req && avs_waitrequest_out)
        begin
            avs_waitrequest_out <= 1'b0;
        end
        else
        begin
            avs_waitrequest_out <= 1'b1;
        end
    end

    // read data loaded alongside the drop of waitrequest
    always_ff @(posedge clock_in)
    begin
        if (!resetn_in)
        begin
            avs_readdata_out <= '0;
        end
        else if (avs_read_in && avs_waitrequest_out)
        begin
            // unmapped addresses read zero
            if (avs_address_in == ADDR_LED_DIRECT)
            begin
                avs_readdata_out <= DATA_W'(led_view);
            end
            else if (avs_address_in == ADDR_PHY_CONTROL)
            begin
                avs_readdata_out <= DATA_W'(phy_view);
            end
            else
            begin
                avs_readdata_out <= '0;
            end
        end
    end

    // stored lamp controls only; bits above read zero
    assign led_view = REG_W'(led_ctrl);

    // phy view; bits below the stretch bypass belong elsewhere
    always_comb
    begin
        phy_view = '0;
        phy_view[PHY_AUTO_X_BIT] = auto_crossover_enable;
        phy_view[PHY_FORCED_X_BIT] = forced_crossover;
        phy_view[PHY_PAUSE_RX_BIT] = pause_rx;
        phy_view[PHY_PAUSE_TX_BIT] = pause_tx;
        phy_view[PHY_FORCE_ERR_BIT] = selftest_force_error;
        phy_view[PHY_PAT_SEL_BIT] = selftest_pattern_select;
        phy_view[PHY_RESULT_BIT] = selftest_result;
        phy_view[PHY_RUN_BIT] = selftest_run;
        phy_view[PHY_BYPASS_BIT] = lamp_stretch_bypass;
    end

    ////////////////////////////////////////////////////////////////////////
    // lamp register: only the nine low bits are stored
    always_ff @(posedge clock_in)
    begin
        if (!resetn_in)
        begin
            led_ctrl <= LED_CTRL_RESET;
        end
        else if (wr_led)
        begin
            if (avs_byteenable_in[0])
            begin
                led_ctrl[7:0] <= avs_writedata_in[7:0];
            end
            if (avs_byteenable_in[1])
            begin
                // bits 15:9 of the write are dropped
                led_ctrl[LED_RX_ONLY_BIT] <= avs_writedata_in[LED_RX_ONLY_BIT];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // phy control bits written by software
    always_ff @(posedge clock_in)
    begin
        if (!resetn_in)
        begin
            // strap sampled while reset is held
            auto_crossover_enable <= auto_crossover_strap_in;
            forced_crossover <= PHY_BIT_RESET;
            selftest_pattern_select <= PHY_BIT_RESET;
            selftest_run <= PHY_BIT_RESET;
        end
        else if (wr_phy && avs_byteenable_in[1])
        begin
            auto_crossover_enable <= avs_writedata_in[PHY_AUTO_X_BIT];
            forced_crossover <= avs_writedata_in[PHY_FORCED_X_BIT];
            selftest_pattern_select <= avs_writedata_in[PHY_PAT_SEL_BIT];
            selftest_run <= avs_writedata_in[PHY_RUN_BIT];
        end
    end

    // stretch bypass sits in the low byte
    always_ff @(posedge clock_in)
    begin
        if (!resetn_in)
        begin
            lamp_stretch_bypass <= PHY_BIT_RESET;
        end
        else if (wr_phy && avs_byteenable_in[0])
        begin
            lamp_stretch_bypass <= avs_writedata_in[PHY_BYPASS_BIT];
        end
    end

    // force error: set by a written one, cleared once injected; set wins
    always_ff @(posedge clock_in)
    begin
        if (!resetn_in)
        begin
            selftest_force_error <= PHY_BIT_RESET;
        end
        else if (wr_phy && avs_byteenable_in[1] && avs_writedata_in[PHY_FORCE_ERR_BIT])
        begin
            selftest_force_error <= 1'b1;
        end
        else if (inject)
        begin
            selftest_force_error <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pause resolution, gated by a full duplex common mode
    always_ff @(posedge clock_in)
    begin
        if (!resetn_in)
        begin
            pause_rx <= PHY_BIT_RESET;
            pause_tx <= PHY_BIT_RESET;
        end
        else
        begin
            // symmetric on both sides, or asymmetric toward the local side
            pause_rx <= hcd_full_duplex_in && pause_local_in.pause
                && (pause_partner_in.pause
                || (pause_local_in.asym_dir && pause_partner_in.asym_dir));
            // symmetric, or local asks to send only
            pause_tx <= hcd_full_duplex_in
                && ((pause_local_in.pause && pause_partner_in.pause)
                || (!pause_local_in.pause && pause_local_in.asym_dir
                && pause_partner_in.pause && pause_partner_in.asym_dir));
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // self-test engine, one cycle behind the run bit
    assign gen_fb = pat_long ? gen[PRBS_LONG_LEN-1] ^ gen[PRBS_LONG_TAP-1]
                             : gen[PRBS_SHORT_LEN-1] ^ gen[PRBS_SHORT_TAP-1];
    assign chk_pred = pat_long ? chk[PRBS_LONG_LEN-1] ^ chk[PRBS_LONG_TAP-1]
                               : chk[PRBS_SHORT_LEN-1] ^ chk[PRBS_SHORT_TAP-1];
    // wait until the checker is armed, or the error would slip by unseen
    assign inject = selftest_active_out && selftest_force_error && fill == 5'(PRBS_LONG_LEN + 1);

    // pattern follows the register only while stopped
    always_ff @(posedge clock_in)
    begin
        if (!resetn_in)
        begin
            selftest_active_out <= 1'b0;
            pat_long <= PHY_BIT_RESET;
        end
        else
        begin
            selftest_active_out <= selftest_run;
            if (!selftest_active_out)
            begin
                pat_long <= selftest_pattern_select;
            end
        end
    end

    // generator and transmitted bit
    always_ff @(posedge clock_in)
    begin
        if (!resetn_in)
        begin
            gen <= PRBS_SEED;
            selftest_tx_out <= 1'b0;
        end
        else if (selftest_active_out)
        begin
            gen <= {gen[PRBS_LONG_LEN-2:0], gen_fb};
            selftest_tx_out <= gen_fb ^ inject;
        end
        else
        begin
            gen <= PRBS_SEED;
            selftest_tx_out <= 1'b0;
        end
    end

    // checker predicts each bit from history once it is full
    always_ff @(posedge clock_in)
    begin
        if (!resetn_in)
        begin
            chk <= '0;
            fill <= '0;
        end
        else if (selftest_active_out)
        begin
            chk <= {chk[PRBS_LONG_LEN-2:0], selftest_rx_in};
            if (fill != 5'(PRBS_LONG_LEN + 1))
            begin
                fill <= fill + 1'b1;
            end
        end
        else
        begin
            fill <= '0;
        end
    end

    // pass from start; any mismatch latches fail until stopped
    always_ff @(posedge clock_in)
    begin
        if (!resetn_in)
        begin
            selftest_result <= PHY_BIT_RESET;
        end
        else if (!selftest_active_out)
        begin
            // a stopped engine shows the reset value; a new run passes first
            selftest_result <= selftest_run;
        end
        else if (fill == 5'(PRBS_LONG_LEN + 1) && selftest_rx_in != chk_pred)
        begin
            selftest_result <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // slow tick for stretching and blinking
    always_ff @(posedge clock_in)
    begin
        if (!resetn_in)
        begin
            div <= '0;
            tick <= 1'b0;
        end
        else if (div == $bits(div)'(TICK_DIV - 1))
        begin
            div <= '0;
            tick <= 1'b1;
        end
        else
        begin
            div <= div + 1'b1;
            tick <= 1'b0;
        end
    end

    // receive-only mode drops transmit traffic from activity
    assign activity = line_status_in.rx_activity
        || (line_status_in.tx_activity && !led_ctrl[LED_RX_ONLY_BIT]);

    ledphy_stretch act_stretch (
        .clock_in(clock_in),
        .resetn_in(resetn_in),
        .tick_in(tick),
        .bypass_in(lamp_stretch_bypass),
        .pulse_in(activity),
        .stretched_out(act_st)
    );

    ledphy_stretch col_stretch (
        .clock_in(clock_in),
        .resetn_in(resetn_in),
        .tick_in(tick),
        .bypass_in(lamp_stretch_bypass),
        .pulse_in(line_status_in.collision),
        .stretched_out(col_st)
    );

    // half blink period in ticks, rounded down
    always_comb
    begin
        case (led_ctrl[LED_BLINK_LSB+1:LED_BLINK_LSB])
            2'h0: blink_half = CNT_W'(TICK_HZ / (2 * BLINK_HZ_0));
            2'h1: blink_half = CNT_W'(TICK_HZ / (2 * BLINK_HZ_1));
            2'h2: blink_half = CNT_W'(TICK_HZ / (2 * BLINK_HZ_2));
            default: blink_half = CNT_W'(TICK_HZ / (2 * BLINK_HZ_3));
        endcase
    end

    // free-running blink phase; rate change takes hold next toggle
    always_ff @(posedge clock_in)
    begin
        if (!resetn_in)
        begin
            blink_cnt <= '0;
            blink_phase <= 1'b0;
        end
        else if (tick)
        begin
            if (blink_cnt == '0)
            begin
                blink_cnt <= blink_half - 1'b1;
                blink_phase <= !blink_phase;
            end
            else
            begin
                blink_cnt <= blink_cnt - 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // lamp outputs with software override
    always_ff @(posedge clock_in)
    begin
        if (!resetn_in)
        begin
            speed_lamp_out <= 1'b0;
            link_lamp_out <= 1'b0;
            activity_collision_lamp_out <= 1'b0;
        end
        else
        begin
            speed_lamp_out <= led_ctrl[LED_SPD_EN_BIT] ? led_ctrl[LED_SPD_VAL_BIT]
                : line_status_in.speed_100;
            link_lamp_out <= led_ctrl[LED_LNK_EN_BIT] ? led_ctrl[LED_LNK_VAL_BIT]
                : (line_status_in.link_up
                && !(line_status_in.blink_on_activity && act_st && blink_phase));
            activity_collision_lamp_out <= led_ctrl[LED_ACT_EN_BIT] ? led_ctrl[LED_ACT_VAL_BIT]
                : (act_st || col_st);
        end
    end

    // crossover controls straight from their register bits
    always_ff @(posedge clock_in)
    begin
        if (!resetn_in)
        begin
            auto_crossover_enable_out <= 1'b0;
            forced_crossover_out <= 1'b0;
        end
        else
        begin
            auto_crossover_enable_out <= auto_crossover_enable;
            forced_crossover_out <= forced_crossover;
        end
    end

endmodule
`default_nettype wire

/* File: tb/ledphy_properties.sv */
/* checker for ledphy_regs: bus timing, read masks, register-to-pin relations.
   assumes it is bound onto the ports of ledphy_regs. */
`timescale 1ns/1ps
`default_nettype none
module ledphy_props
    import ledphy_pkg::*;
(
    input wire logic clock_in,
    input wire logic resetn_in,
    input wire logic [ADDR_W-1:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [DATA_W-1:0] avs_writedata_in,
    input wire logic [DATA_W/8-1:0] avs_byteenable_in,
    input wire logic [DATA_W-1:0] avs_readdata_out,
    input wire logic avs_waitrequest_out,
    input wire logic auto_crossover_enable_out,
    input wire logic forced_crossover_out,
    input wire logic selftest_active_out
);
    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (!resetn_in);
    // completed read, phy write
    wire logic rd_done = avs_read_in && !avs_waitrequest_out;
    wire logic wr_phy = avs_write_in && !avs_waitrequest_out && avs_address_in == ADDR_PHY_CONTROL
        && avs_byteenable_in[1];
    ////////////////////////////////////////////////////////////////////////
    a_one_wait_state: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out)
        else $error("late answer");
    a_wait_low_once: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
        else $error("long answer");
    a_upper_half_zero: assert property (rd_done |-> avs_readdata_out[31:16] == 16'h0000)
        else $error("upper half");
    a_lamp_rsvd_zero: assert property (rd_done && avs_address_in == ADDR_LED_DIRECT |-> avs_readdata_out[15:9] == 7'h00)
        else $error("lamp reserved");
    a_phy_low_zero: assert property (rd_done && avs_address_in == ADDR_PHY_CONTROL |-> avs_readdata_out[6:0] == 7'h00)
        else $error("phy low bits");
    a_unmapped_zero: assert property (rd_done && avs_address_in != ADDR_LED_DIRECT
        && avs_address_in != ADDR_PHY_CONTROL |-> avs_readdata_out == 32'h0000_0000)
        else $error("unmapped read");
    a_auto_x_pin: assert property (wr_phy |-> ##2 auto_crossover_enable_out == $past(avs_writedata_in[15], 2))
        else $error("auto crossover");
    a_forced_x_pin: assert property (wr_phy |-> ##2 forced_crossover_out == $past(avs_writedata_in[14], 2))
        else $error("forced crossover");
    a_selftest_run: assert property (wr_phy |-> ##2 selftest_active_out == $past(avs_writedata_in[8], 2))
        else $error("self-test run");
    // main scenarios reached
    c_lamp_read: cover property (rd_done && avs_address_in == ADDR_LED_DIRECT);
    c_phy_write: cover property (wr_phy);
    c_selftest_on: cover property ($rose(selftest_active_out));
endmodule
bind ledphy_regs ledphy_props u_props (.clock_in, .resetn_in, .avs_address_in, .avs_read_in, .avs_write_in,
    .avs_writedata_in, .avs_byteenable_in, .avs_readdata_out, .avs_waitrequest_out, .auto_crossover_enable_out,
    .forced_crossover_out, .selftest_active_out);
`default_nettype wire

/* File: tb/tb_top.sv */
/* self-checking bench for ledphy_regs over Avalon-MM.
   assumes a 4-cycle tick divider and self-test data looped back. */
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import ledphy_pkg::*;
;
    localparam int DIV = 4; // short tick
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [ADDR_W-1:0] addr = '0;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [DATA_W-1:0] wdata = '0;
    ledphy_line_status_s ls = '0;
    ledphy_pause_adv_s loc = '0;
    ledphy_pause_adv_s par = '0;
    logic fdx = 1'b0;
    wire logic [DATA_W-1:0] rdata;
    wire logic wreq, spd, lnk, act, ax, fx, st_tx, st_act;
    int num_errors = 0;
    int n_checks = 0;
    int half [4] = '{83, 41, 20, 10}; // blink half periods in ticks
    int n;
    // self-test looped back
    ledphy_regs #(.TICK_DIV(DIV)) dut (.clock_in(clk), .resetn_in(rstn), .avs_address_in(addr),
        .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata), .avs_byteenable_in(4'hF),
        .avs_readdata_out(rdata), .avs_waitrequest_out(wreq), .line_status_in(ls), .pause_local_in(loc),
        .pause_partner_in(par), .hcd_full_duplex_in(fdx), .auto_crossover_strap_in(1'b1),
        .selftest_rx_in(st_tx), .speed_lamp_out(spd), .link_lamp_out(lnk), .activity_collision_lamp_out(act),
        .auto_crossover_enable_out(ax), .forced_crossover_out(fx), .selftest_tx_out(st_tx),
        .selftest_active_out(st_act));
    initial
        forever #2.5 clk = ~clk;
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string name, input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // held until waitrequest low
    task automatic bus(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
        output logic [DATA_W-1:0] q);
        @(posedge clk);
        addr <= a;
        wr <= w;
        rd <= !w;
        wdata <= d;
        @(posedge clk);
        while (wreq !== 1'b0)
            @(posedge clk);
        q = rdata;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask
    task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        logic [DATA_W-1:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rd_chk(input string name, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
        logic [DATA_W-1:0] q;
        bus(1'b0, a, '0, q);
        check(name, q, exp);
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // hang guard
    initial
    begin
        #(5 * 30000);
        num_errors++;
        end_of_test();
    end
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        rd_chk("lamp reset", ADDR_LED_DIRECT, 32'h0);
        rd_chk("phy reset", ADDR_PHY_CONTROL, 32'h8000);
        wr_reg(8'h10, 32'hFFFF_FFFF);
        rd_chk("unmapped", 8'h10, 32'h0);
        wr_reg(ADDR_LED_DIRECT, 32'hFFFF_FE3D);
        rd_chk("lamp stored", ADDR_LED_DIRECT, 32'h3D);
        repeat (3) @(posedge clk);
        check("lamps forced", 32'({spd, lnk, act}), 32'h5);
        wr_reg(ADDR_LED_DIRECT, 32'h7);
        rd_chk("lamp not pins", ADDR_LED_DIRECT, 32'h7);
        check("lamps normal", 32'({spd, lnk, act}), 32'h0);
        $display("test lamp register done");
        fdx <= 1'b1;
        loc <= 2'b01;
        par <= 2'b01;
        wr_reg(ADDR_PHY_CONTROL, 32'hC000);
        rd_chk("pause sym", ADDR_PHY_CONTROL, 32'hF000);
        check("crossover pins", 32'({ax, fx}), 32'h3);
        loc <= 2'b10;
        par <= 2'b11;
        repeat (3) @(posedge clk);
        rd_chk("pause asym", ADDR_PHY_CONTROL, 32'hD000);
        fdx <= 1'b0;
        repeat (3) @(posedge clk);
        rd_chk("pause half dup", ADDR_PHY_CONTROL, 32'hC000);
        $display("test crossover and pause done");
        wr_reg(ADDR_PHY_CONTROL, 32'h100);
        repeat (40) @(posedge clk);
        rd_chk("bist pass", ADDR_PHY_CONTROL, 32'h300);
        wr_reg(ADDR_PHY_CONTROL, 32'h900);
        repeat (40) @(posedge clk);
        rd_chk("bist forced fail", ADDR_PHY_CONTROL, 32'h100);
        wr_reg(ADDR_PHY_CONTROL, 32'h0);
        rd_chk("bist stopped", ADDR_PHY_CONTROL, 32'h0);
        wr_reg(ADDR_PHY_CONTROL, 32'h500);
        repeat (60) @(posedge clk);
        rd_chk("bist long pass", ADDR_PHY_CONTROL, 32'h700);
        $display("test self-test done");
        wr_reg(ADDR_LED_DIRECT, 32'h100);
        wr_reg(ADDR_PHY_CONTROL, 32'h80);
        ls.tx_activity <= 1'b1;
        repeat (4) @(posedge clk);
        check("tx with rx only", 32'(act), 32'h0);
        wr_reg(ADDR_LED_DIRECT, 32'h0);
        repeat (4) @(posedge clk);
        check("tx counts", 32'(act), 32'h1);
        ls.tx_activity <= 1'b0;
        repeat (4) @(posedge clk);
        check("raw when bypassed", 32'(act), 32'h0);
        wr_reg(ADDR_PHY_CONTROL, 32'h0);
        ls.tx_activity <= 1'b1;
        repeat (2) @(posedge clk);
        ls.tx_activity <= 1'b0;
        repeat (20) @(posedge clk);
        check("stretched", 32'(act), 32'h1);
        $display("test activity done");
        wr_reg(ADDR_PHY_CONTROL, 32'h80);
        ls <= 6'b100101;
        for (int f = 0; f < 4; f++)
        begin
            wr_reg(ADDR_LED_DIRECT, DATA_W'(f << 6));
            @(posedge lnk);
            n = 0;
            while (lnk === 1'b1)
            begin
                @(posedge clk);
                n++;
            end
            check("blink half", 32'(n > half[f] * DIV - 6 && n < half[f] * DIV + 6), 32'h1);
        end
        $display("test blink done");
        end_of_test();
    end
endmodule
`default_nettype wire
